// ==== verilog/dbp_onchip_debug_port.sv ====
// On-chip debug port: mode register, pin sharing, serial debug link,
// break state and event masking.
// Assumes a classic Wishbone master on sys_clk_i and raw debug pins.
//
// How it works
// RQ1: Debug reset pin low asynchronously clears the whole debug control unit.
// RQ2: Emulator releases debug reset only after sensing target supply.
// RQ3: Every rise of debug reset pulses the CPU reset output.
// RQ4: Emulator supplies the debug clock at 20 MHz; the dbp_emu model runs it at 6.25 MHz (160 ns period).
// RQ5: Select and serial input are taken on rising debug clock edges.
// RQ6: Serial output changes only on falling debug clock edges.
// RQ7: Transfer state advances by the level of the select line.
// RQ8: Without target supply the emulator floats all its outputs.
// RQ9: Flash-mode pin stays high for a whole self-programming download.
// RQ10: Emulator floats flash-mode pin normally, drives high for break download.
// RQ11: Emulator uses system reset to revive a disabled debug reset pin; dbp_emu has no system reset output, the bench drives the system resets.
// RQ12: Debugger may mask reset, NMI, watchdog NMI, wait and hold.
// RQ13: Mode register takes a write only right after the protect key.
// RQ14: Mode register takes writes only while debug reset is low.
// RQ15: Mode register allows byte and single-bit access.
// RQ16: External reset pin sets mode to 01H; other resets keep it.
// RQ17: Enable bit 0 gives pins to ports and drops the pull-down.
// RQ18: Debug mode only with enable bit 1 and debug reset high.
// RQ19: User keeps debug reset low to use the pins as ports.
// RQ20: Pin reset during a break resets neither CPU nor peripherals.
// RQ21: Target or watchdog reset disables soft breakpoints until next break.
// RQ22: In debug mode the serial output pin is driven, idling high.
// RQ23: Framing: 8-bit LSB-first command, 8-bit LSB-first status reply.
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none

module dbp_onchip_debug_port
    import dbp_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [DAT_W-1:0] wb_dat_i,
    output logic [DAT_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    // Debug pins
    input wire logic debug_reset_n_i,
    input wire logic debug_clock_in_i,
    input wire logic debug_transfer_select_i,
    input wire logic debug_serial_in_i,
    output logic debug_serial_out_o,
    output logic debug_serial_out_oe_o,
    // Pin sharing
    output logic debug_pins_active_o,
    output logic debug_pulldown_en_o,
    // Event sources
    input wire logic ext_reset_n_i,
    input wire logic nmi_pin_i,
    input wire logic wait_pin_i,
    input wire logic hold_request_i,
    input wire logic watchdog_nmi_request_i,
    input wire logic watchdog_reset_i,
    input wire logic clock_monitor_reset_i,
    input wire logic low_voltage_detector_reset_i,
    input wire logic hw_break_i,
    // Gated events to the core
    output logic cpu_reset_o,
    output logic nmi_o,
    output logic watchdog_nmi_o,
    output logic wait_o,
    output logic hold_o,
    output logic break_o
);
    // ========================================================
    // Pin synchronisers
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_s;
    logic debug_reset_n_s, dck_s, dms_s, ddi_s, ext_rst_s;
    logic dck_q_ff, debug_reset_n_q_ff;
    logic dck_rise, dck_fall, debug_reset_n_rise;

    assign pin_raw = {hold_request_i, wait_pin_i, nmi_pin_i, ext_reset_n_i,
                      debug_serial_in_i, debug_transfer_select_i,
                      debug_clock_in_i, debug_reset_n_i};

    dbp_sync #(.W(PIN_W), .RST_VAL(PIN_RST)) u_pin_sync (
        .clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .d_i(pin_raw),
        .q_o(pin_s)
    );

    assign debug_reset_n_s = pin_s[P_DEBUG_RESET_N];
    assign dck_s = pin_s[P_DCK];
    assign dms_s = pin_s[P_DMS];
    assign ddi_s = pin_s[P_DDI];
    assign ext_rst_s = ~pin_s[P_EXTRST];

    // Edge history of debug clock and debug reset
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dck_q_ff <= 1'b0;
            debug_reset_n_q_ff <= 1'b0;
        end else begin
            dck_q_ff <= dck_s;
            debug_reset_n_q_ff <= debug_reset_n_s;
        end
    end

    assign dck_rise = dck_s & ~dck_q_ff; // [RQ5]
    assign dck_fall = ~dck_s & dck_q_ff; // [RQ6]
    assign debug_reset_n_rise = debug_reset_n_s & ~debug_reset_n_q_ff;

    // ========================================================
    // Wishbone slave and mode register
    logic wb_req, wb_wr, wb_ack_ff;
    logic [DAT_W-1:0] wb_dat_ff;
    logic prot_armed_ff;
    logic [7:0] mode_ff;
    logic mode_wr_ok;
    logic debug_mode;
    logic [MSK_W-1:0] mask_ff;
    logic brk_ff, swbp_en_ff;

    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_ff;
    assign wb_wr = wb_req & wb_we_i;
    assign mode_wr_ok = wb_wr & (wb_adr_i == ADDR_MODE) & wb_sel_i[0]
                        & prot_armed_ff & ~debug_reset_n_s; // [RQ13] [RQ14] [RQ15]

    // One-wait-state ack, read data registered
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wb_ack_ff <= 1'b0;
            wb_dat_ff <= '0;
        end else begin
            wb_ack_ff <= wb_req;
            if (wb_req && !wb_we_i) begin
                unique case (wb_adr_i)
                    ADDR_MODE: wb_dat_ff <= {24'h000000, mode_ff}; // [RQ15]
                    ADDR_STAT: wb_dat_ff <= {28'h0000000, swbp_en_ff, brk_ff,
                                             debug_pins_active_o, debug_reset_n_s};
                    ADDR_MASK: wb_dat_ff <= {27'h0000000, mask_ff};
                    default: wb_dat_ff <= '0;
                endcase
            end
        end
    end

    // Protect key arms exactly the next bus write
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            prot_armed_ff <= 1'b0;
        end else if (wb_wr) begin
            prot_armed_ff <= (wb_adr_i == ADDR_PROT) & wb_sel_i[0]
                             & (wb_dat_i[7:0] == PROT_KEY); // [RQ13]
        end
    end

    // Mode register; external pin reset wins over a write
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mode_ff <= MODE_RST;
        end else if (ext_rst_s) begin
            mode_ff <= MODE_RST; // [RQ16]
        end else if (mode_wr_ok) begin
            mode_ff <= wb_dat_i[7:0] & MODE_WMASK; // [RQ13] [RQ14]
        end
    end

    assign debug_mode = mode_ff[MODE_EN_BIT] & debug_reset_n_s; // [RQ18]

    // Pin ownership and pull-down control
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            debug_pins_active_o <= 1'b0;
            debug_pulldown_en_o <= MODE_RST[MODE_EN_BIT];
            debug_serial_out_oe_o <= 1'b0;
        end else begin
            debug_pins_active_o <= debug_mode; // [RQ18] [RQ17]
            debug_pulldown_en_o <= mode_ff[MODE_EN_BIT]; // [RQ17]
            debug_serial_out_oe_o <= debug_mode; // [RQ22]
        end
    end

    // ========================================================
    // Debug control unit, cleared while the debug reset pin is low
    logic dcu_arst_n;
    dbp_xfer_e st_ff;
    logic [2:0] bit_cnt_ff;
    logic [CMD_BITS-1:0] shreg_ff, reply_ff;
    logic [CMD_BITS-1:0] cmd_next;
    logic cmd_exec;

    assign dcu_arst_n = resetn_i & debug_reset_n_i; // [RQ1]
    assign cmd_next = {ddi_s, shreg_ff[CMD_BITS-1:1]};
    assign cmd_exec = debug_mode & dck_rise & dms_s & (st_ff == DBP_SHIFT)
                      & (bit_cnt_ff == BIT_LAST);

    // Transfer state steered by the select line
    always_ff @(posedge sys_clk_i or negedge dcu_arst_n) begin
        if (!dcu_arst_n) begin
            st_ff <= DBP_IDLE; // [RQ1]
            bit_cnt_ff <= '0;
            shreg_ff <= '0;
            reply_ff <= '0;
        end else if (!debug_mode) begin
            st_ff <= DBP_IDLE;
            bit_cnt_ff <= '0;
        end else begin
            unique case (st_ff)
                DBP_IDLE: begin
                    if (dck_rise && dms_s) begin
                        st_ff <= DBP_SHIFT; // [RQ7]
                        shreg_ff <= cmd_next; // [RQ23]
                        bit_cnt_ff <= 3'h1;
                    end
                end
                DBP_SHIFT: begin
                    if (dck_rise) begin
                        if (!dms_s) begin
                            st_ff <= DBP_IDLE; // [RQ7]
                        end else if (bit_cnt_ff == BIT_LAST) begin
                            st_ff <= DBP_REPLY;
                            bit_cnt_ff <= '0;
                            reply_ff <= {swbp_en_ff, brk_ff, debug_mode, mask_ff}; // [RQ23]
                        end else begin
                            shreg_ff <= cmd_next; // [RQ5]
                            bit_cnt_ff <= bit_cnt_ff + 3'h1;
                        end
                    end
                end
                DBP_REPLY: begin
                    if (dck_rise && dms_s) begin
                        st_ff <= DBP_IDLE; // [RQ7]
                    end else if (dck_fall) begin
                        reply_ff <= {1'b0, reply_ff[CMD_BITS-1:1]};
                        bit_cnt_ff <= bit_cnt_ff + 3'h1;
                        if (bit_cnt_ff == BIT_LAST) begin
                            st_ff <= DBP_IDLE;
                        end
                    end
                end
                default: st_ff <= DBP_IDLE;
            endcase
        end
    end

    // Serial output moves on falling edges and idles high
    always_ff @(posedge sys_clk_i or negedge dcu_arst_n) begin
        if (!dcu_arst_n) begin
            debug_serial_out_o <= 1'b1;
        end else if (dck_fall) begin
            debug_serial_out_o <= (st_ff == DBP_REPLY) ? reply_ff[0] : 1'b1; // [RQ6] [RQ22]
        end
    end

    // Break state and masks set by debugger commands
    always_ff @(posedge sys_clk_i or negedge dcu_arst_n) begin
        if (!dcu_arst_n) begin
            brk_ff <= 1'b0;
            mask_ff <= '0;
        end else if (cmd_exec) begin
            unique case (cmd_next[7:5])
                OP_BREAK: brk_ff <= 1'b1;
                OP_RUN: brk_ff <= 1'b0;
                OP_MASK: mask_ff <= cmd_next[MSK_W-1:0]; // [RQ12]
                default: brk_ff <= brk_ff;
            endcase
        end
    end

    // ========================================================
    // Software breakpoint enable; a new break wins over a reset
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            swbp_en_ff <= 1'b1;
        end else if (hw_break_i || (cmd_exec && cmd_next[7:5] == OP_BREAK)) begin
            swbp_en_ff <= 1'b1; // [RQ21]
        end else if (ext_rst_s || watchdog_reset_i) begin
            swbp_en_ff <= 1'b0; // [RQ21]
        end
    end

    // ========================================================
    // CPU reset generation and event gating
    logic [2:0] rst_cnt_ff;
    logic pin_rst_req, int_rst_req;

    assign pin_rst_req = ext_rst_s & ~brk_ff & ~mask_ff[MSK_RESET]; // [RQ20] [RQ12]
    assign int_rst_req = (watchdog_reset_i | clock_monitor_reset_i
                          | low_voltage_detector_reset_i) & ~mask_ff[MSK_RESET];

    // Pulse stretch after debug reset release
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_cnt_ff <= '0;
        end else if (debug_reset_n_rise) begin
            rst_cnt_ff <= CPU_RST_LOAD; // [RQ3]
        end else if (rst_cnt_ff != 3'h0) begin
            rst_cnt_ff <= rst_cnt_ff - 3'h1;
        end
    end

    // Registered gated outputs
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cpu_reset_o <= 1'b1;
            nmi_o <= 1'b0;
            watchdog_nmi_o <= 1'b0;
            wait_o <= 1'b0;
            hold_o <= 1'b0;
            break_o <= 1'b0;
        end else begin
            cpu_reset_o <= debug_reset_n_rise | (rst_cnt_ff != 3'h0)
                           | pin_rst_req | int_rst_req; // [RQ3] [RQ20]
            nmi_o <= pin_s[P_NMI] & ~mask_ff[MSK_NMI]; // [RQ12]
            watchdog_nmi_o <= watchdog_nmi_request_i & ~mask_ff[MSK_WDTNMI]; // [RQ12]
            wait_o <= pin_s[P_WAIT] & ~mask_ff[MSK_WAIT]; // [RQ12]
            hold_o <= pin_s[P_HOLD] & ~mask_ff[MSK_HOLD]; // [RQ12]
            break_o <= brk_ff;
        end
    end

    assign wb_ack_o = wb_ack_ff;
    assign wb_dat_o = wb_dat_ff;

    // ========================================================
    // Assertions
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_debug_reset_n_rise;
        debug_reset_n_rise;
    endsequence

    sequence s_rst_pulse;
        cpu_reset_o [*4];
    endsequence

    a_cpu_rst_pulse: assert property (s_debug_reset_n_rise |=> s_rst_pulse) // [RQ3]
        else $error("CPU reset pulse too short after debug reset rise");

    a_mode_ext_rst: assert property (ext_rst_s |=> mode_ff == MODE_RST) // [RQ16]
        else $error("External reset did not restore mode register");

    a_mode_lock_high: assert property (debug_reset_n_s && wb_wr && !ext_rst_s |=> $stable(mode_ff)) // [RQ14]
        else $error("Mode register changed while debug reset high");

    a_mode_unarmed: assert property (!prot_armed_ff && !ext_rst_s |=> $stable(mode_ff)) // [RQ13]
        else $error("Mode register changed without protect key");

    a_pins_follow: assert property (1'b1 |=> debug_pins_active_o ==
                                    ($past(mode_ff[MODE_EN_BIT]) && $past(debug_reset_n_s))) // [RQ18]
        else $error("Debug pin ownership wrong");

    a_pulldown_off: assert property (!mode_ff[MODE_EN_BIT] |=> !debug_pulldown_en_o) // [RQ17]
        else $error("Pull-down kept with enable bit clear");

    a_out_enable: assert property (debug_pins_active_o |-> debug_serial_out_oe_o) // [RQ22]
        else $error("Serial output not driven in debug mode");

    a_out_on_fall: assert property (disable iff (!dcu_arst_n)
                                    !dck_fall |=> $stable(debug_serial_out_o)) // [RQ6]
        else $error("Serial output changed outside a falling edge");

    a_xfer_start: assert property (disable iff (!dcu_arst_n)
        debug_mode && st_ff == DBP_IDLE && dck_rise && dms_s |=> st_ff == DBP_SHIFT) // [RQ7]
        else $error("Transfer did not start on select high");

    a_pin_rst_break: assert property (brk_ff && rst_cnt_ff == 3'h0 && !debug_reset_n_rise
        && !int_rst_req |=> !cpu_reset_o) // [RQ20]
        else $error("Pin reset reached CPU during break");

    a_swbp_clear: assert property (watchdog_reset_i && !hw_break_i && !cmd_exec
                                   |=> !swbp_en_ff) // [RQ21]
        else $error("Watchdog reset left soft breakpoints enabled");
endmodule // dbp_onchip_debug_port

`default_nettype wire

// ==== verilog/dbp_pkg.sv ====
// Constants, register map and encodings for the on-chip debug port.
// Assumes a 100 MHz system clock and a 28-bit Wishbone byte address.
`default_nettype none

package dbp_pkg;
    // ========================================================
    // Bus and register map
    localparam int ADR_W = 28;
    localparam int DAT_W = 32;
    localparam logic [27:0] ADDR_MODE = 28'hFFFF9FC; // Debug mode control
    localparam logic [27:0] ADDR_PROT = 28'hFFFF9F8; // Protect key
    localparam logic [27:0] ADDR_STAT = 28'hFFFF9F4; // Status, read only
    localparam logic [27:0] ADDR_MASK = 28'hFFFF9F0; // Mask set, read only
    localparam logic [7:0] MODE_RST = 8'h01;
    localparam logic [7:0] MODE_WMASK = 8'h01;
    localparam logic [7:0] PROT_KEY = 8'hA5;
    localparam int MODE_EN_BIT = 0;

    // ========================================================
    // Pin synchroniser lanes
    localparam int PIN_W = 8;
    localparam int P_DEBUG_RESET_N = 0;
    localparam int P_DCK = 1;
    localparam int P_DMS = 2;
    localparam int P_DDI = 3;
    localparam int P_EXTRST = 4;
    localparam int P_NMI = 5;
    localparam int P_WAIT = 6;
    localparam int P_HOLD = 7;
    localparam logic [7:0] PIN_RST = 8'h10;

    // ========================================================
    // Event mask bits
    localparam int MSK_W = 5;
    localparam int MSK_RESET = 0;
    localparam int MSK_NMI = 1;
    localparam int MSK_WDTNMI = 2;
    localparam int MSK_WAIT = 3;
    localparam int MSK_HOLD = 4;

    // ========================================================
    // Serial command framing
    localparam int CMD_BITS = 8;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] OP_STATUS = 3'h0;
    localparam logic [2:0] OP_BREAK = 3'h1;
    localparam logic [2:0] OP_RUN = 3'h2;
    localparam logic [2:0] OP_MASK = 3'h3;

    typedef enum logic [1:0] {
        DBP_IDLE = 2'b00,
        DBP_SHIFT = 2'b01,
        DBP_REPLY = 2'b11
    } dbp_xfer_e;

    // ========================================================
    // Timing
    localparam int CLK_MHZ = 100;
    localparam int CPU_RST_NS = 40;
    localparam int CPU_RST_CYC = (CPU_RST_NS * CLK_MHZ + 999) / 1000;
    localparam logic [2:0] CPU_RST_LOAD = 3'(CPU_RST_CYC - 1);
endpackage

`default_nettype wire

// ==== verilog/dbp_sync.sv ====
// Two flip-flop synchroniser for a group of pins.
// Assumes the inputs are asynchronous to clk_i.
`timescale 1ns/100ps
`default_nettype none

module dbp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Data
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    // First stage feeds only the second
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta_ff <= RST_VAL;
            sync_ff <= RST_VAL;
        end else begin
            meta_ff <= d_i;
            sync_ff <= meta_ff;
        end
    end

    assign q_o = sync_ff;
endmodule // dbp_sync

`default_nettype wire

// ==== tb/dbp_emu.sv ====
// Behavioural debug emulator model: drives the debug pins, collects replies.
// Assumes the bench calls its tasks one at a time, from a single process.
`timescale 1ns/100ps
`default_nettype none

module dbp_emu (
    // Target side
    input wire logic supply_ok_i,
    input wire logic debug_serial_out_i,
    // Emulator outputs
    output logic debug_reset_n_o,
    output logic debug_clock_in_o,
    output logic debug_transfer_select_o,
    output logic debug_serial_in_o
);
    localparam int HALF = 80; // Half of the 160 ns link clock

    // ========================================================
    // Idle levels, link clock stands still between frames
    initial begin
        debug_reset_n_o = 1'b0;
        debug_clock_in_o = 1'b0;
        debug_transfer_select_o = 1'b0;
        debug_serial_in_o = 1'b0;
    end

    // Flash-mode line, left floating in normal operation
    logic flash_mode_pin = 'z;

    // No target supply: every emulator output floats
    always @(negedge supply_ok_i) begin
        {debug_reset_n_o, debug_clock_in_o} = 'z;
        {debug_transfer_select_o, debug_serial_in_o, flash_mode_pin} = 'z;
    end

    // Break download holds the flash-mode line high throughout
    task automatic download(input int n);
        flash_mode_pin = 1'b1;
        #(n * HALF);
        flash_mode_pin = 'z;
    endtask

    // Debug reset, released only once target supply is seen
    task automatic set_debug_reset_n(input logic v);
        #3;
        if (v) wait (supply_ok_i === 1'b1);
        debug_reset_n_o = v;
    endtask

    // One frame: 8 command bits out, 8 reply bits in, both LSB first
    task automatic xfer(input logic [7:0] cmd, output logic [7:0] rep);
        #3;
        for (int i = 0; i < 16; i++) begin
            debug_transfer_select_o = (i < 8);
            debug_serial_in_o = (i < 8) ? cmd[i] : ~debug_serial_in_o;
            #HALF debug_clock_in_o = 1'b1;
            if (i >= 8) rep[i-8] = debug_serial_out_i;
            #HALF debug_clock_in_o = 1'b0;
        end
    endtask
endmodule // dbp_emu

`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the on-chip debug port.
// Assumes the emulator model drives the debug pins; bench drives the rest.
`timescale 1ns/100ps
`default_nettype none

module tb
    import dbp_pkg::*;
;
    typedef struct packed {
        logic key;
        logic debug_reset_n;
        logic [7:0] d;
        logic [7:0] mode;
        logic act;
    } dbp_row_s;

    logic sys_clk_i, resetn_i, wb_cyc_i, wb_stb_i, wb_we_i;
    logic [ADR_W-1:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [DAT_W-1:0] wb_dat_i, wb_dat_o;
    logic wb_ack_o, debug_serial_out_o, debug_serial_out_oe_o;
    logic debug_pins_active_o, debug_pulldown_en_o;
    logic ext_reset_n_i, nmi_pin_i, wait_pin_i, hold_request_i, watchdog_nmi_request_i;
    logic watchdog_reset_i, clock_monitor_reset_i, low_voltage_detector_reset_i, hw_break_i;
    logic cpu_reset_o, nmi_o, watchdog_nmi_o, wait_o, hold_o, break_o;
    logic supply_ok;
    wire logic debug_reset_n_i, debug_clock_in_i, debug_transfer_select_i, debug_serial_in_i;
    wire logic ddo_pin;
    int n_mismatch = 0;
    int n_tests = 0;
    int cnt;
    logic [31:0] q;
    logic [7:0] rep;
    dbp_row_s rows [4] = '{'{1'b0, 1'b0, 8'h00, 8'h01, 1'b0}, '{1'b1, 1'b0, 8'h00, 8'h00, 1'b0},
        '{1'b1, 1'b0, 8'hFF, 8'h01, 1'b0}, '{1'b1, 1'b1, 8'h00, 8'h01, 1'b1}};
    logic [27:0] r_adr [4] = '{ADDR_MODE, ADDR_STAT, ADDR_MASK, 28'h0000100};
    logic [31:0] r_exp [4] = '{32'h00000001, 32'h00000008, 32'h00000000, 32'h00000000};

    // Released serial line shows the inverse, not the last value
    assign ddo_pin = debug_serial_out_oe_o ? debug_serial_out_o : ~debug_serial_out_o;

    dbp_onchip_debug_port u_dbp_onchip_debug_port (
        .sys_clk_i, .resetn_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .debug_reset_n_i, .debug_clock_in_i,
        .debug_transfer_select_i, .debug_serial_in_i, .debug_serial_out_o,
        .debug_serial_out_oe_o, .debug_pins_active_o, .debug_pulldown_en_o, .ext_reset_n_i,
        .nmi_pin_i, .wait_pin_i, .hold_request_i, .watchdog_nmi_request_i, .watchdog_reset_i,
        .clock_monitor_reset_i, .low_voltage_detector_reset_i, .hw_break_i, .cpu_reset_o,
        .nmi_o, .watchdog_nmi_o, .wait_o, .hold_o, .break_o
    );

    dbp_emu u_dbp_emu (
        .supply_ok_i(supply_ok), .debug_serial_out_i(ddo_pin),
        .debug_reset_n_o(debug_reset_n_i), .debug_clock_in_o(debug_clock_in_i),
        .debug_transfer_select_o(debug_transfer_select_i), .debug_serial_in_o(debug_serial_in_i)
    );

    // ========================================================
    // Clock, 100 MHz
    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_sim();
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask

    // Classic Wishbone single cycle, waits for ack under a bound
    task automatic wb(input logic we, input logic [27:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge sys_clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= {24'h000000, d};
        wb_sel_i <= 4'hF;
        @(posedge sys_clk_i);
        while (wb_ack_o !== 1'b1 && n < 50) begin
            n++;
            @(posedge sys_clk_i);
        end
        q = wb_dat_o;
        if (n >= 50) chk("wb_ack_o", 32'h0, 32'h1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    // Mode write, optionally after the protect key
    task automatic pwr(input logic key, input logic [7:0] d);
        if (key) wb(1'b1, ADDR_PROT, PROT_KEY);
        wb(1'b1, ADDR_MODE, d);
    endtask

    // One-cycle event pulse: bit 0 hw break, 1 watchdog, 2 clock monitor, 3 low voltage
    task automatic pulse(input logic [3:0] ev);
        @(posedge sys_clk_i);
        {low_voltage_detector_reset_i, clock_monitor_reset_i, watchdog_reset_i,
         hw_break_i} <= ev;
        @(posedge sys_clk_i);
        {low_voltage_detector_reset_i, clock_monitor_reset_i, watchdog_reset_i,
         hw_break_i} <= 4'h0;
        cyc(3);
    endtask

    task automatic frame(input logic [7:0] cmd, input logic [7:0] exp);
        u_dbp_emu.xfer(cmd, rep);
        chk("reply", rep, exp);
        cyc(5);
    endtask

    // ========================================================
    // Main sequence
    initial begin
        {resetn_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
        {nmi_pin_i, wait_pin_i, hold_request_i, watchdog_nmi_request_i} = 4'h0;
        {watchdog_reset_i, clock_monitor_reset_i, low_voltage_detector_reset_i} = 3'h0;
        hw_break_i = 1'b0;
        ext_reset_n_i = 1'b1;
        supply_ok = 1'b1;
        cyc(10);
        resetn_i <= 1'b1;
        cyc(3);
        // Protected mode writes against debug reset level
        foreach (rows[k]) begin
            u_dbp_emu.set_debug_reset_n(rows[k].debug_reset_n);
            cyc(10);
            pwr(rows[k].key, rows[k].d);
            wb(1'b0, ADDR_MODE, 8'h00);
            chk("mode", q, {24'h0, rows[k].mode});
            cyc(3);
            chk("pins_active", debug_pins_active_o, rows[k].act);
            chk("pulldown", debug_pulldown_en_o, rows[k].mode[0]);
        end
        // CPU reset pulse on each debug reset rise
        u_dbp_emu.set_debug_reset_n(1'b0);
        cyc(10);
        u_dbp_emu.set_debug_reset_n(1'b1);
        cnt = 0;
        repeat (20) begin
            @(posedge sys_clk_i);
            if (cpu_reset_o === 1'b1) cnt++;
        end
        chk("cpu_reset len", cnt, CPU_RST_CYC);
        chk("ddo", {debug_serial_out_o, debug_serial_out_oe_o}, 32'h3);
        // Soft breakpoints: cleared by watchdog reset, set again by hw break
        pulse(4'h2);
        wb(1'b0, ADDR_STAT, 8'h00);
        chk("softbp clr", q[3], 32'h0);
        pulse(4'h1);
        wb(1'b0, ADDR_STAT, 8'h00);
        chk("softbp set", q[3], 32'h1);
        frame(8'h40, 8'hA0);
        frame(8'h00, 8'hA0);
        // Event masking
        {nmi_pin_i, wait_pin_i, hold_request_i, watchdog_nmi_request_i} <= 4'hF;
        cyc(5);
        chk("events", {nmi_o, watchdog_nmi_o, wait_o, hold_o}, 32'hF);
        frame(8'h7F, 8'hA0);
        frame(8'h00, 8'hBF);
        chk("events masked", {nmi_o, watchdog_nmi_o, wait_o, hold_o}, 32'h0);
        wb(1'b0, ADDR_MASK, 8'h00);
        chk("mask reg", q, 32'h1F);
        {nmi_pin_i, wait_pin_i, hold_request_i, watchdog_nmi_request_i} <= 4'h0;
        frame(8'h60, 8'hBF);
        // Pin reset masked during a break
        frame(8'h20, 8'hA0);
        chk("break", break_o, 32'h1);
        u_dbp_emu.download(4);
        ext_reset_n_i <= 1'b0;
        cnt = 0;
        repeat (10) begin
            @(posedge sys_clk_i);
            if (cpu_reset_o === 1'b1) cnt++;
        end
        ext_reset_n_i <= 1'b1;
        chk("break pin reset", cnt, 32'h0);
        // Debug reset low clears the debug unit asynchronously
        u_dbp_emu.set_debug_reset_n(1'b0);
        cyc(5);
        chk("break cleared", break_o, 32'h0);
        // Internal resets keep the mode, pin reset restores 01H
        pwr(1'b1, 8'h00);
        pulse(4'h4);
        pulse(4'h8);
        pulse(4'h2);
        wb(1'b0, ADDR_MODE, 8'h00);
        chk("mode kept", q, 32'h0);
        ext_reset_n_i <= 1'b0;
        cyc(5);
        ext_reset_n_i <= 1'b1;
        cyc(5);
        wb(1'b0, ADDR_MODE, 8'h00);
        chk("mode pin reset", q, 32'h1);
        // Mid-run reset, then reset values and an unmapped read
        pwr(1'b1, 8'h00);
        resetn_i <= 1'b0;
        cyc(3);
        resetn_i <= 1'b1;
        cyc(3);
        foreach (r_adr[k]) begin
            wb(1'b0, r_adr[k], 8'h00);
            chk("reset value", q, r_exp[k]);
        end
        end_sim();
    end

    // Watchdog: run takes well under 100 us
    initial begin
        #200000;
        n_mismatch++;
        end_sim();
    end
endmodule // tb

`default_nettype wire
